// ==== synth_serial_regs.vh ====
// Field positions, select codes, monitor codes and reset values for the serial register load
`ifndef SYNTH_SERIAL_REGS_VH
`define SYNTH_SERIAL_REGS_VH

`define SEL_DIVIDE        3'h0
`define SEL_PHASE         3'h1
`define SEL_REFDEN        3'h2
`define SEL_FUNCTION      3'h3
`define SEL_CLKDIV        3'h4

`define MON_HI            30
`define MON_LO            27
`define INT_HI            26
`define INT_LO            15
`define FRAC_HI           14
`define FRAC_LO           3
`define PHASE_HI          14
`define PHASE_LO          3
`define LMODE_HI          30
`define LMODE_LO          29
`define SLIP_BIT          28
`define PUMP_HI           27
`define PUMP_LO           24
`define PRESC_BIT         22
`define HALVER_BIT        21
`define DOUBLER_BIT       20
`define RCNT_HI           19
`define RCNT_LO           15
`define DEN_HI            14
`define DEN_LO            3
`define SDRST_BIT         14
`define LOCKWIN_BIT       7
`define POLAR_BIT         6
`define PWRDN_BIT         5
`define PUMP3S_BIT        4
`define CNTRST_BIT        3
`define CDMODE_HI         20
`define CDMODE_LO         19
`define CDVAL_HI          18
`define CDVAL_LO          7

`define MON_TRISTATE      4'h0
`define MON_HIGH          4'h1
`define MON_LOW           4'h2
`define MON_SDO           4'h7
`define MON_CLKDIV        4'hA

`define RST_WORD12        12'h000
`define RST_DEN           12'h002
`define RST_INT           12'h017
`define RST_RCNT          5'h01
`define RST_MON           4'h0

`endif

// ==== synth_serial_register_load.v ====
// Serial three-wire programming front end with five configuration latches
//
// Function
// - Shift serial data MSB first on clock rise
// - Load strobe rise copies word into latch
// - Low three bits select target latch
// - Buffered settings wait for next latch 0
// - Latch 0 holds monitor, integer, fraction
// - Reference counter divides by 1 to 32
// - Comparison rate uses doubler and halver bits
// - Latch 1 holds twelve-bit phase value
// - Latch 2 holds reference and denominator fields
// - Latch 3 holds function control bits
// - Latch 4 holds clock divider mode, value
// - Monitor select field steers monitor pin
// - Monitor codes: tristate, high, low, data, divider
// - Chip enable low powers down, pump tristate
`timescale 1ns/1ps
`default_nettype none
`include "synth_serial_regs.vh"

module synth_serial_register_load #(
	parameter WORD_W = 32,
	parameter VAL_W  = 12
) (
	// Clock and reset
	input  wire               clk,
	input  wire               rst_n,
	// Three-wire programming pins
	input  wire               serial_clk,
	input  wire               serial_data,
	input  wire               load_strobe,
	// Chip enable pin
	input  wire               chip_enable,
	// Reference input, already a clean square wave
	input  wire               reference_input,
	// Monitor output pin as two signals
	output reg                monitor_output_pin,
	output reg                monitor_output_oe_n,
	// Active divide settings
	output reg  [VAL_W-1:0]   int_value,
	output reg  [VAL_W-1:0]   frac_value,
	output reg  [VAL_W-1:0]   partial_denominator,
	output reg  [VAL_W-1:0]   phase_value,
	output reg  [4:0]         ref_count,
	output reg                ref_doubler,
	output reg                reference_halver,
	output reg  [3:0]         pump_current_code,
	// Settings without buffering
	output reg  [1:0]         lock_mode,
	output reg                slip_reduction_enable,
	output reg                prescaler_sel,
	output reg                sd_reset,
	output reg                lock_window_select,
	output reg                detector_polarity,
	output reg                power_down,
	output reg                pump_tristate,
	output reg                counter_reset,
	output reg  [1:0]         clkdiv_mode,
	output reg  [VAL_W-1:0]   clkdiv_value,
	// Comparison clock enable toward the detector
	output reg                compare_pulse
);

	// Pin synchronisers
	reg  [1:0]        sclk_sync_q;
	reg  [1:0]        sdat_sync_q;
	reg  [1:0]        le_sync_q;
	reg  [1:0]        ce_sync_q;
	reg  [1:0]        ref_sync_q;
	reg               sclk_prev_q;
	reg               le_prev_q;
	reg               ref_prev_q;
	wire              sclk_rise;
	wire              le_rise;
	wire              ref_rise;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_sync_q <= 2'h0;
			sdat_sync_q <= 2'h0;
			le_sync_q   <= 2'h0;
			ce_sync_q   <= 2'h3;
			ref_sync_q  <= 2'h0;
			sclk_prev_q <= 1'b0;
			le_prev_q   <= 1'b0;
			ref_prev_q  <= 1'b0;
		end
		else
		begin
			sclk_sync_q <= {sclk_sync_q[0], serial_clk};
			sdat_sync_q <= {sdat_sync_q[0], serial_data};
			le_sync_q   <= {le_sync_q[0], load_strobe};
			ce_sync_q   <= {ce_sync_q[0], chip_enable};
			ref_sync_q  <= {ref_sync_q[0], reference_input};
			sclk_prev_q <= sclk_sync_q[1];
			le_prev_q   <= le_sync_q[1];
			ref_prev_q  <= ref_sync_q[1];
		end
	end

	assign sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;
	assign le_rise   = le_sync_q[1] & ~le_prev_q;
	assign ref_rise  = ref_sync_q[1] & ~ref_prev_q;

	// Shift register
	reg  [WORD_W-1:0] shift_q;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			shift_q <= {WORD_W{1'b0}};
		else if (sclk_rise)
			shift_q <= {shift_q[WORD_W-2:0], sdat_sync_q[1]};
	end

	// Pending copies of buffered settings, plus monitor select and power-down/three-state bits
	reg  [VAL_W-1:0]  den_pend_q;
	reg  [VAL_W-1:0]  phase_pend_q;
	reg  [4:0]        rcnt_pend_q;
	reg               dbl_pend_q;
	reg               half_pend_q;
	reg  [3:0]        pump_pend_q;
	reg  [3:0]        mon_sel_q;
	reg               pwrdn_q;
	reg               tri3s_q;
	wire [2:0]        sel;

	assign sel = shift_q[2:0];

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			den_pend_q            <= `RST_DEN;
			phase_pend_q          <= `RST_WORD12;
			rcnt_pend_q           <= `RST_RCNT;
			dbl_pend_q            <= 1'b0;
			half_pend_q           <= 1'b0;
			pump_pend_q           <= 4'h0;
			mon_sel_q             <= `RST_MON;
			int_value             <= `RST_INT;
			frac_value            <= `RST_WORD12;
			partial_denominator   <= `RST_DEN;
			phase_value           <= `RST_WORD12;
			ref_count             <= `RST_RCNT;
			ref_doubler           <= 1'b0;
			reference_halver      <= 1'b0;
			pump_current_code     <= 4'h0;
			lock_mode             <= 2'h0;
			slip_reduction_enable <= 1'b0;
			prescaler_sel         <= 1'b0;
			sd_reset              <= 1'b0;
			lock_window_select    <= 1'b0;
			detector_polarity     <= 1'b0;
			pwrdn_q               <= 1'b0;
			tri3s_q               <= 1'b0;
			counter_reset         <= 1'b0;
			clkdiv_mode           <= 2'h0;
			clkdiv_value          <= `RST_WORD12;
		end
		else
		begin
			if (le_rise)
			begin
				case (sel)
					`SEL_DIVIDE:
					begin
						mon_sel_q           <= shift_q[`MON_HI:`MON_LO];
						int_value           <= shift_q[`INT_HI:`INT_LO];
						frac_value          <= shift_q[`FRAC_HI:`FRAC_LO];
						partial_denominator <= den_pend_q;
						phase_value         <= phase_pend_q;
						ref_count           <= rcnt_pend_q;
						ref_doubler         <= dbl_pend_q;
						reference_halver    <= half_pend_q;
						pump_current_code   <= pump_pend_q;
					end
					`SEL_PHASE:
						phase_pend_q <= shift_q[`PHASE_HI:`PHASE_LO];
					`SEL_REFDEN:
					begin
						lock_mode             <= shift_q[`LMODE_HI:`LMODE_LO];
						slip_reduction_enable <= shift_q[`SLIP_BIT];
						pump_pend_q           <= shift_q[`PUMP_HI:`PUMP_LO];
						prescaler_sel         <= shift_q[`PRESC_BIT];
						half_pend_q           <= shift_q[`HALVER_BIT];
						dbl_pend_q            <= shift_q[`DOUBLER_BIT];
						rcnt_pend_q           <= shift_q[`RCNT_HI:`RCNT_LO];
						den_pend_q            <= shift_q[`DEN_HI:`DEN_LO];
					end
					`SEL_FUNCTION:
					begin
						sd_reset           <= shift_q[`SDRST_BIT];
						lock_window_select <= shift_q[`LOCKWIN_BIT];
						detector_polarity  <= shift_q[`POLAR_BIT];
						pwrdn_q            <= shift_q[`PWRDN_BIT];
						tri3s_q            <= shift_q[`PUMP3S_BIT];
						counter_reset      <= shift_q[`CNTRST_BIT];
					end
					`SEL_CLKDIV:
					begin
						clkdiv_mode  <= shift_q[`CDMODE_HI:`CDMODE_LO];
						clkdiv_value <= shift_q[`CDVAL_HI:`CDVAL_LO];
					end
					default:
						mon_sel_q <= mon_sel_q;
				endcase
			end
		end
	end

	// Chip enable low forces power-down and pump three-state
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			power_down    <= 1'b0;
			pump_tristate <= 1'b0;
		end
		else
		begin
			power_down    <= pwrdn_q | ~ce_sync_q[1];
			pump_tristate <= tri3s_q | ~ce_sync_q[1];
		end
	end

	// Reference path: optional doubling, count of 1 to 32, optional halving
	reg  [4:0]        ref_cnt_q;
	reg               half_tog_q;
	reg  [VAL_W-1:0]  cdiv_cnt_q;
	reg               cdiv_out_q;
	wire              ref_tick;
	wire              r_tick;
	wire              active;

	assign active   = ce_sync_q[1] & ~power_down & ~counter_reset;
	assign ref_tick = ref_doubler ? (ref_sync_q[1] ^ ref_prev_q) : ref_rise;
	assign r_tick   = ref_tick & (ref_cnt_q == (ref_count - 5'h01));

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ref_cnt_q     <= 5'h00;
			half_tog_q    <= 1'b0;
			compare_pulse <= 1'b0;
			cdiv_cnt_q    <= `RST_WORD12;
			cdiv_out_q    <= 1'b0;
		end
		else if (!active)
		begin
			ref_cnt_q     <= 5'h00;
			half_tog_q    <= 1'b0;
			compare_pulse <= 1'b0;
			cdiv_cnt_q    <= `RST_WORD12;
			cdiv_out_q    <= 1'b0;
		end
		else
		begin
			if (ref_tick)
				ref_cnt_q <= r_tick ? 5'h00 : ref_cnt_q + 5'h01;
			if (r_tick)
				half_tog_q <= ~half_tog_q;
			compare_pulse <= r_tick & (~reference_halver | half_tog_q);
			if (compare_pulse && clkdiv_mode != 2'h0)
			begin
				if (cdiv_cnt_q >= clkdiv_value)
				begin
					cdiv_cnt_q <= `RST_WORD12;
					cdiv_out_q <= ~cdiv_out_q;
				end
				else
					cdiv_cnt_q <= cdiv_cnt_q + 12'h001;
			end
		end
	end

	// Monitor pin multiplexer
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			monitor_output_pin  <= 1'b0;
			monitor_output_oe_n <= 1'b1;
		end
		else
		begin
			monitor_output_oe_n <= 1'b0;
			case (mon_sel_q)
				`MON_TRISTATE:
				begin
					monitor_output_pin  <= 1'b0;
					monitor_output_oe_n <= 1'b1;
				end
				`MON_HIGH:   monitor_output_pin <= 1'b1;
				`MON_LOW:    monitor_output_pin <= 1'b0;
				`MON_SDO:    monitor_output_pin <= shift_q[WORD_W-1];
				`MON_CLKDIV: monitor_output_pin <= cdiv_out_q;
				default:     monitor_output_pin <= 1'b0;
			endcase
		end
	end

endmodule
`default_nettype wire

// ==== synth_serial_chk.sv ====
// Timing checker for the serial register load ports
`timescale 1ns/1ps
`default_nettype none
module synth_serial_chk #(
	parameter VAL_W = 12
) (
	// Clock, reset and pins
	input wire logic		clk,
	input wire logic		rst_n,
	input wire logic		load_strobe,
	input wire logic		chip_enable,
	// Observed outputs
	input wire logic [VAL_W-1:0]	int_value,
	input wire logic [VAL_W-1:0]	partial_denominator,
	input wire logic [VAL_W-1:0]	phase_value,
	input wire logic		monitor_output_oe_n,
	input wire logic		power_down,
	input wire logic		pump_tristate,
	input wire logic		compare_pulse
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence strobe_rise;
		!load_strobe ##1 load_strobe;
	endsequence
	sequence off_run;
		!chip_enable [*4];
	endsequence
	int_load_a: assert property ($changed(int_value) |-> $past(load_strobe, 3))
		else $error("integer changed without strobe");
	load_latency_a: assert property (strobe_rise |-> ##1 $stable(int_value) [*2])
		else $error("integer changed too early");
	den_load_a: assert property ($changed(partial_denominator) |-> $past(load_strobe, 3))
		else $error("denominator changed without strobe");
	phase_load_a: assert property ($changed(phase_value) |-> $past(load_strobe, 3))
		else $error("phase changed without strobe");
	enable_off_a: assert property (off_run |-> power_down && pump_tristate)
		else $error("disabled chip not powered down");
	pulse_single_a: assert property (compare_pulse |=> !compare_pulse)
		else $error("compare pulse too long");
	pulse_stop_a: assert property (power_down [*4] |-> !compare_pulse)
		else $error("compare pulse while powered down");
	mon_load_a: assert property ($changed(monitor_output_oe_n) |-> $past(load_strobe, 4))
		else $error("monitor enable changed without strobe");
endmodule
bind synth_serial_register_load synth_serial_chk #(.VAL_W(VAL_W)) u_synth_serial_chk (
	.clk(clk), .rst_n(rst_n), .load_strobe(load_strobe), .chip_enable(chip_enable),
	.int_value(int_value), .partial_denominator(partial_denominator),
	.phase_value(phase_value), .monitor_output_oe_n(monitor_output_oe_n),
	.power_down(power_down), .pump_tristate(pump_tristate), .compare_pulse(compare_pulse));
`default_nettype wire

// ==== host_model.sv ====
// Host model driving the three-wire programming pins
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// Clock
	input wire logic	clk,
	// Three-wire pins
	output var logic	serial_clk,
	output var logic	serial_data,
	output var logic	load_strobe
);
	initial
	begin
		serial_clk = 1'b0;
		serial_data = 1'b0;
		load_strobe = 1'b0;
	end
	task automatic send_word(input logic [31:0] w, input int slow);
		int i;
		for (i = 31; i >= 0; i--)
		begin
			serial_data = w[i];
			repeat (3 + slow) @(negedge clk);
			serial_clk = 1'b1;
			repeat (5 + slow) @(negedge clk);
			serial_clk = 1'b0;
		end
		serial_data = ~w[0];
		repeat (5) @(negedge clk);
		load_strobe = 1'b1;
		repeat (8) @(negedge clk);
		load_strobe = 1'b0;
		repeat (4) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the serial register load
`timescale 1ns/1ps
`default_nettype none
`include "synth_serial_regs.vh"
module tb_top;
	logic		clk, rst_n, chip_enable, reference_input;
	wire		serial_clk, serial_data, load_strobe, mon_pin, mon_oe_n, cp;
	wire [11:0]	iv_o, fr_o, den_o, ph_o, cdv_o;
	wire [4:0]	rc_o;
	wire [3:0]	pc_o;
	wire [1:0]	lm_o, cdm_o;
	wire [9:0]	b_o;
	wire [95:0]	all_o = {iv_o, fr_o, den_o, ph_o, cdv_o, rc_o, pc_o, lm_o, cdm_o, b_o, mon_pin, mon_oe_n};
	int		n_mismatch, checks, i, k;
	logic [31:0]	w;
	logic [11:0]	den, ph, iv, fr;
	logic [95:0]	snap;
	host_model u_host_model (.clk(clk), .serial_clk(serial_clk), .serial_data(serial_data),
		.load_strobe(load_strobe));
	synth_serial_register_load #(.WORD_W(32), .VAL_W(12)) u_synth_serial_register_load (
		.clk(clk), .rst_n(rst_n), .serial_clk(serial_clk), .serial_data(serial_data),
		.load_strobe(load_strobe), .chip_enable(chip_enable), .reference_input(reference_input),
		.monitor_output_pin(mon_pin), .monitor_output_oe_n(mon_oe_n), .int_value(iv_o),
		.frac_value(fr_o), .partial_denominator(den_o), .phase_value(ph_o), .ref_count(rc_o),
		.ref_doubler(b_o[9]), .reference_halver(b_o[8]), .pump_current_code(pc_o),
		.lock_mode(lm_o), .slip_reduction_enable(b_o[7]), .prescaler_sel(b_o[6]),
		.sd_reset(b_o[5]), .lock_window_select(b_o[4]), .detector_polarity(b_o[3]),
		.power_down(b_o[2]), .pump_tristate(b_o[1]), .counter_reset(b_o[0]),
		.clkdiv_mode(cdm_o), .clkdiv_value(cdv_o), .compare_pulse(cp));
	task automatic chk(input logic [95:0] g, input logic [95:0] e);
		checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic send(input logic [31:0] x);
		u_host_model.send_word(x, $urandom_range(2));
	endtask
	function automatic int exp_p(input logic [4:0] r, input logic d, input logic t);
		return (r == 5'h00 ? 32 : r) * 8 * (1 + t) / (1 + d);
	endfunction
	task automatic period(input int e);
		int n;
		n = 0;
		repeat (60) @(negedge clk);
		for (k = 0; k < 600 && cp !== 1'b1; k++) @(negedge clk);
		@(negedge clk);
		for (n = 1; n < 600 && cp !== 1'b1; n++) @(negedge clk);
		chk(n, e);
	endtask
	task automatic report_and_stop;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always
	begin
		repeat (4) @(negedge clk);
		reference_input = ~reference_input;
	end
	initial
	begin
		#4000000;
		n_mismatch++;
		report_and_stop;
	end
	initial
	begin
		n_mismatch = 0;
		checks = 0;
		rst_n = 1'b0;
		chip_enable = 1'b1;
		reference_input = 1'b0;
		i = $urandom(32'h1374);
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk({iv_o, den_o, rc_o, mon_oe_n}, {`RST_INT, `RST_DEN, `RST_RCNT, 1'b1});
		$display("test reset done");
		ph = `RST_WORD12;
		for (i = 0; i < 4; i++)
		begin
			den = 12'($urandom_range(4095, 2));
			w = {1'b0, 7'($urandom), 1'b0, 1'($urandom), 7'($urandom), den, `SEL_REFDEN};
			if (i == 0)
				w[21:15] = 7'h21;
			snap = den_o;
			send(w);
			chk({lm_o, b_o[7:6], den_o}, {w[30:28], w[22], snap[11:0]});
			snap = ph_o;
			ph = 12'($urandom);
			send({17'h0, ph, `SEL_PHASE});
			chk(ph_o, snap);
			iv = 12'($urandom_range(4095, 23));
			fr = 12'($urandom_range(den - 1));
			send({1'b0, `MON_HIGH, iv, fr, `SEL_DIVIDE});
			chk({rc_o, b_o[9:8], pc_o, den_o}, {w[19:15], w[20], w[21], w[27:24], den});
			chk({ph_o, iv_o, fr_o, mon_oe_n, mon_pin}, {ph, iv, fr, 2'b01});
			period(exp_p(w[19:15], w[20], w[21]));
		end
		$display("test buffered done");
		for (i = 0; i < 3; i++)
		begin
			send({1'b0, 4'(i), 12'h017, 12'h000, `SEL_DIVIDE});
			chk({mon_oe_n, mon_pin}, {i == 0, i == 1});
		end
		for (i = 7; i < 11; i += 3)
		begin
			send({1'b0, 4'(i), 12'h017, 12'h000, `SEL_DIVIDE});
			chk({mon_oe_n, mon_pin}, 2'b00);
		end
		$display("test monitor done");
		w = {17'h0, 1'($urandom), 6'h0, 5'($urandom), `SEL_FUNCTION};
		send(w);
		chk(b_o[5:0], {w[14], w[7:3]});
		w = {11'h0, 14'($urandom), 4'h0, `SEL_CLKDIV};
		send(w);
		chk({cdm_o, cdv_o}, w[20:7]);
		send({1'b0, `MON_HIGH, 12'h017, 12'h000, `SEL_DIVIDE});
		for (i = 5; i < 8; i++)
		begin
			snap = all_o;
			send({29'($urandom), 3'(i)});
			chk(all_o, snap);
		end
		$display("test latches done");
		send({32'h0, `SEL_FUNCTION});
		send({11'h0, 2'h1, 12'h001, 4'h0, `SEL_CLKDIV});
		send({12'h0, 5'h01, 12'h002, `SEL_REFDEN});
		send({1'b0, `MON_CLKDIV, 12'h017, 12'h000, `SEL_DIVIDE});
		repeat (300) @(negedge clk);
		snap = mon_pin;
		for (k = 0; k < 600 && mon_pin === snap[0]; k++) @(negedge clk);
		snap = mon_pin;
		@(negedge clk);
		for (i = 1; i < 600 && mon_pin === snap[0]; i++) @(negedge clk);
		chk(i, exp_p(5'h01, 1'b0, 1'b0) * 2);
		$display("test divider done");
		send({32'h0, `SEL_FUNCTION});
		chip_enable = 1'b0;
		repeat (5) @(negedge clk);
		chk(b_o[2:1], 2'b11);
		k = 0;
		repeat (100)
		begin
			@(negedge clk);
			k += (cp !== 1'b0);
		end
		chk(k, 0);
		chip_enable = 1'b1;
		repeat (5) @(negedge clk);
		chk(b_o[2:1], 2'b00);
		$display("test enable done");
		report_and_stop;
	end
endmodule
`default_nettype wire
